/* verilog/bst_defines.vh */
// Constants for the boundary scan test access port
`ifndef BST_DEFINES_VH
`define BST_DEFINES_VH

// Instruction register
`define BST_IR_W          3
`define BST_IR_EXTEST     3'h0
`define BST_IR_SAMPLE     3'h4
`define BST_IR_IDCODE     3'h6
`define BST_IR_BYPASS     3'h7
`define BST_IR_CAPTURE    3'h1

// Data register selection codes
`define BST_SEL_W         2
`define BST_SEL_BYP       2'h0
`define BST_SEL_ID        2'h1
`define BST_SEL_CHAIN     2'h2

// Identification word layout
`define BST_ID_W          32
`define BST_ID_FIXED      1'h1
`define BST_ID_PROD_W     11
`define BST_ID_PART_W     16
`define BST_ID_REV_W      4
// Arbitrary identity values
`define BST_ID_PROD_DEF   11'h05a
`define BST_ID_PART_DEF   16'h1234
`define BST_ID_REV_DEF    4'h1

// Boundary chain
`define BST_CHAIN_LEN     98
`define BST_PIN_IN_N      49
`define BST_PIN_OUT_N     49

// Controller states
`define BST_ST_W          4
`define BST_ST_TLR        4'hf
`define BST_ST_RTI        4'hc
`define BST_ST_SELDR      4'h7
`define BST_ST_CAPDR      4'h6
`define BST_ST_SHDR       4'h2
`define BST_ST_EX1DR      4'h1
`define BST_ST_PDR        4'h3
`define BST_ST_EX2DR      4'h0
`define BST_ST_UPDR       4'h5
`define BST_ST_SELIR      4'h4
`define BST_ST_CAPIR      4'he
`define BST_ST_SHIR       4'ha
`define BST_ST_EX1IR      4'h9
`define BST_ST_PIR        4'hb
`define BST_ST_EX2IR      4'h8
`define BST_ST_UPIR       4'hd

`endif

/* verilog/bst_sync.v */
// Two-stage synchroniser for signals from outside the clock domain
`timescale 1ns/1ps
`default_nettype none

module bst_sync #(
  parameter W = 1
) (
  // Clock and reset
  input  wire         clk_i,
  input  wire         reset_i,
  // Asynchronous in, synchronised out
  input  wire [W-1:0] async_i,
  output wire [W-1:0] sync_o
);

  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  // First stage feeds only the second stage
  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end
    else
    begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule // bst_sync
`default_nettype wire

/* verilog/bst_chain.v */
// Boundary scan chain with capture, shift and latched parallel update
`timescale 1ns/1ps
`default_nettype none

module bst_chain #(
  parameter LEN = 98
) (
  // Clock and reset
  input  wire           clk_i,
  input  wire           reset_i,
  // Control strobes, one cycle each
  input  wire           capture_i,
  input  wire           shift_i,
  input  wire           update_i,
  // Serial path
  input  wire           si_i,
  output wire           so_o,
  // Parallel capture and update
  input  wire [LEN-1:0] cap_i,
  output wire [LEN-1:0] upd_o
);

  reg [LEN-1:0] sh_q;
  reg [LEN-1:0] upd_q;

  genvar i;
  generate
    for (i = 0; i < LEN; i = i + 1)
    begin : g_stage
      // Each stage captures its pin or takes its upstream neighbour
      always @(posedge clk_i)
      begin
        if (reset_i)
          sh_q[i] <= 1'b0;
        else if (capture_i)
          sh_q[i] <= cap_i[i];
        else if (shift_i)
          sh_q[i] <= (i == LEN - 1) ? si_i : sh_q[(i + 1) % LEN];
      end

      // Parallel latch changes only on the update strobe
      always @(posedge clk_i)
      begin
        if (reset_i)
          upd_q[i] <= 1'b0;
        else if (update_i)
          upd_q[i] <= sh_q[i];
      end
    end
  endgenerate

  assign so_o  = sh_q[0];
  assign upd_o = upd_q;

endmodule // bst_chain
`default_nettype wire

/* verilog/bst_tap.v */
// Boundary scan test access port: controller, instruction and data registers
//
// Functional notes
// - Three-bit instruction, shifted in LSB first
// - Extest: chain drives pins, captures inputs
// - Sample/preload: chain in path, core drives pins
// - Idcode selects identification register
// - Bypass gives one test-clock delay
// - Identification word fields and fixed one
// - Identification shifts out LSB first
// - Bypass register is a single bit
// - 98-stage chain, used by extest/sample only
// - Chain captures input pins and core outputs, drives the output pins only
// - Sixteen-state controller, DR and IR branches
// - Mode-select sampled at test-clock rise
// - Serial data timed by test clock
// - Five high mode-select edges reach reset
// - Test reset restores normal mode, idcode
// - Chain outputs update on falling edge only
`timescale 1ns/1ps
`default_nettype none
`include "bst_defines.vh"

module bst_tap #(
  parameter              PIN_IN_N  = `BST_PIN_IN_N,
  parameter              PIN_OUT_N = `BST_PIN_OUT_N,
  parameter [`BST_ID_PROD_W-1:0] ID_PROD = `BST_ID_PROD_DEF,
  parameter [`BST_ID_PART_W-1:0] ID_PART = `BST_ID_PART_DEF,
  parameter [`BST_ID_REV_W-1:0]  ID_REV  = `BST_ID_REV_DEF
) (
  // Clock and reset
  input  wire                 clk_i,
  input  wire                 reset_i,
  // Test access pins
  input  wire                 tck_i,
  input  wire                 tms_i,
  input  wire                 tdi_i,
  output wire                 tdo_o,
  output wire                 tdo_oe_o,
  // Pin side of the boundary
  input  wire [PIN_IN_N-1:0]  pin_in_i,
  output wire [PIN_OUT_N-1:0] pin_out_o,
  // Core side of the boundary
  input  wire [PIN_OUT_N-1:0] core_out_i,
  output wire [PIN_IN_N-1:0]  core_in_o,
  // Status
  output wire                 test_mode_o
);

  localparam CHAIN_LEN = PIN_IN_N + PIN_OUT_N;

  // Data register select from the current instruction
  function [`BST_SEL_W-1:0] dr_sel;
    input [`BST_IR_W-1:0] ir;
    begin
      case (ir)
        `BST_IR_EXTEST: dr_sel = `BST_SEL_CHAIN;
        `BST_IR_SAMPLE: dr_sel = `BST_SEL_CHAIN;
        `BST_IR_IDCODE: dr_sel = `BST_SEL_ID;
        `BST_IR_BYPASS: dr_sel = `BST_SEL_BYP;
        default:        dr_sel = `BST_SEL_BYP;
      endcase
    end
  endfunction

  // Synchronised test pins and boundary inputs
  wire [2:0]          tap_sync;
  wire [PIN_IN_N-1:0] pin_in_sync;
  wire                tck_s;
  wire                tms_s;
  wire                tdi_s;

  bst_sync #(
    .W (3)
  ) u_tap_sync (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .async_i ({tck_i, tms_i, tdi_i}),
    .sync_o  (tap_sync)
  );

  bst_sync #(
    .W (PIN_IN_N)
  ) u_pin_sync (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .async_i (pin_in_i),
    .sync_o  (pin_in_sync)
  );

  assign tck_s = tap_sync[2];
  assign tms_s = tap_sync[1];
  assign tdi_s = tap_sync[0];

  // Test clock edge detection
  reg  tck_prev_q;
  wire tck_rise;
  wire tck_fall;

  // Cleared to the idle-low level so no false edge follows reset
  always @(posedge clk_i)
  begin
    if (reset_i)
      tck_prev_q <= 1'b0;
    else
      tck_prev_q <= tck_s;
  end

  assign tck_rise = tck_s & ~tck_prev_q;
  assign tck_fall = ~tck_s & tck_prev_q;

  // Controller state
  reg [`BST_ST_W-1:0] st_q;
  reg [`BST_ST_W-1:0] st_d;

  // Next state from mode-select at each test-clock rise
  always @*
  begin
    st_d = st_q;
    case (st_q)
      `BST_ST_TLR:   st_d = tms_s ? `BST_ST_TLR   : `BST_ST_RTI;
      `BST_ST_RTI:   st_d = tms_s ? `BST_ST_SELDR : `BST_ST_RTI;
      `BST_ST_SELDR: st_d = tms_s ? `BST_ST_SELIR : `BST_ST_CAPDR;
      `BST_ST_CAPDR: st_d = tms_s ? `BST_ST_EX1DR : `BST_ST_SHDR;
      `BST_ST_SHDR:  st_d = tms_s ? `BST_ST_EX1DR : `BST_ST_SHDR;
      `BST_ST_EX1DR: st_d = tms_s ? `BST_ST_UPDR  : `BST_ST_PDR;
      `BST_ST_PDR:   st_d = tms_s ? `BST_ST_EX2DR : `BST_ST_PDR;
      `BST_ST_EX2DR: st_d = tms_s ? `BST_ST_UPDR  : `BST_ST_SHDR;
      `BST_ST_UPDR:  st_d = tms_s ? `BST_ST_SELDR : `BST_ST_RTI;
      `BST_ST_SELIR: st_d = tms_s ? `BST_ST_TLR   : `BST_ST_CAPIR;
      `BST_ST_CAPIR: st_d = tms_s ? `BST_ST_EX1IR : `BST_ST_SHIR;
      `BST_ST_SHIR:  st_d = tms_s ? `BST_ST_EX1IR : `BST_ST_SHIR;
      `BST_ST_EX1IR: st_d = tms_s ? `BST_ST_UPIR  : `BST_ST_PIR;
      `BST_ST_PIR:   st_d = tms_s ? `BST_ST_EX2IR : `BST_ST_PIR;
      `BST_ST_EX2IR: st_d = tms_s ? `BST_ST_UPIR  : `BST_ST_SHIR;
      `BST_ST_UPIR:  st_d = tms_s ? `BST_ST_SELDR : `BST_ST_RTI;
      default:       st_d = `BST_ST_TLR;
    endcase
  end

  // State advances only on a test-clock rise; power-up lands in reset
  always @(posedge clk_i)
  begin
    if (reset_i)
      st_q <= `BST_ST_TLR;
    else if (tck_rise)
      st_q <= st_d;
  end

  // State decodes
  wire in_tlr   = (st_q == `BST_ST_TLR);
  wire in_capdr = (st_q == `BST_ST_CAPDR);
  wire in_shdr  = (st_q == `BST_ST_SHDR);
  wire in_updr  = (st_q == `BST_ST_UPDR);
  wire in_capir = (st_q == `BST_ST_CAPIR);
  wire in_shir  = (st_q == `BST_ST_SHIR);
  wire in_upir  = (st_q == `BST_ST_UPIR);

  // Instruction shift stage and active instruction
  reg [`BST_IR_W-1:0] ir_sh_q;
  reg [`BST_IR_W-1:0] ir_q;

  // Capture loads the fixed pattern, shift takes data in LSB first
  always @(posedge clk_i)
  begin
    if (reset_i)
      ir_sh_q <= `BST_IR_CAPTURE;
    else if (tck_rise && in_capir)
      ir_sh_q <= `BST_IR_CAPTURE;
    else if (tck_rise && in_shir)
      ir_sh_q <= {tdi_s, ir_sh_q[`BST_IR_W-1:1]};
  end

  // Active instruction: idcode in reset, new code on update falling edge
  always @(posedge clk_i)
  begin
    if (reset_i)
      ir_q <= `BST_IR_IDCODE;
    else if (in_tlr)
      ir_q <= `BST_IR_IDCODE;
    else if (tck_fall && in_upir)
      ir_q <= ir_sh_q;
  end

  wire [`BST_SEL_W-1:0] sel = dr_sel(ir_q);

  // Bypass register, one bit
  reg byp_q;

  always @(posedge clk_i)
  begin
    if (reset_i)
      byp_q <= 1'b0;
    else if (tck_rise && in_capdr && sel == `BST_SEL_BYP)
      byp_q <= 1'b0;
    else if (tck_rise && in_shdr && sel == `BST_SEL_BYP)
      byp_q <= tdi_s;
  end

  // Identification register
  wire [`BST_ID_W-1:0] id_word = {ID_REV, ID_PART, ID_PROD,
                                  `BST_ID_FIXED};
  reg  [`BST_ID_W-1:0] id_q;

  // Loads on capture, shifts right so bit 0 leaves first
  always @(posedge clk_i)
  begin
    if (reset_i)
      id_q <= {`BST_ID_W{1'b0}};
    else if (tck_rise && in_capdr && sel == `BST_SEL_ID)
      id_q <= id_word;
    else if (tck_rise && in_shdr && sel == `BST_SEL_ID)
      id_q <= {tdi_s, id_q[`BST_ID_W-1:1]};
  end

  // Boundary chain, active only for extest and sample/preload
  wire                 chain_sel = (sel == `BST_SEL_CHAIN);
  wire                 chain_so;
  wire [CHAIN_LEN-1:0] chain_upd;

  bst_chain #(
    .LEN (CHAIN_LEN)
  ) u_chain (
    .clk_i     (clk_i),
    .reset_i   (reset_i),
    .capture_i (tck_rise & in_capdr & chain_sel),
    .shift_i   (tck_rise & in_shdr & chain_sel),
    .update_i  (tck_fall & in_updr & chain_sel),
    .si_i      (tdi_s),
    .so_o      (chain_so),
    .cap_i     ({core_out_i, pin_in_sync}),
    .upd_o     (chain_upd)
  );

  // Extest takes the pins; outside test reset only
  wire extest = (ir_q == `BST_IR_EXTEST) & ~in_tlr;

  // Pin drivers: chain pattern under extest, core path otherwise
  reg [PIN_OUT_N-1:0] pin_out_q;
  reg [PIN_IN_N-1:0]  core_in_q;

  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      pin_out_q <= {PIN_OUT_N{1'b0}};
      core_in_q <= {PIN_IN_N{1'b0}};
    end
    else
    begin
      pin_out_q <= extest ? chain_upd[CHAIN_LEN-1:PIN_IN_N]
                          : core_out_i;
      core_in_q <= pin_in_sync;
    end
  end

  // Serial output selection
  // Instruction scans take the output ahead of any data register
  reg tdo_d;

  always @*
  begin
    if (in_shir)
      tdo_d = ir_sh_q[0];
    else
      case (sel)
        `BST_SEL_CHAIN: tdo_d = chain_so;
        `BST_SEL_ID:    tdo_d = id_q[0];
        default:        tdo_d = byp_q;
      endcase
  end

  // Serial output changes on falling edge, driven only while shifting
  reg tdo_q;
  reg tdo_oe_q;

  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      tdo_q    <= 1'b0;
      tdo_oe_q <= 1'b0;
    end
    else if (tck_fall)
    begin
      tdo_q    <= tdo_d;
      tdo_oe_q <= in_shir | in_shdr;
    end
  end

  assign tdo_o       = tdo_q;
  assign tdo_oe_o    = tdo_oe_q;
  assign pin_out_o   = pin_out_q;
  assign core_in_o   = core_in_q;
  assign test_mode_o = extest;

endmodule // bst_tap
`default_nettype wire

/* verification/bst_tap_monitor.sv */
// Checker for the boundary scan test access port
`timescale 1ns/1ps
`default_nettype none
module bst_tap_monitor #(
  parameter PIN_IN_N  = 49,
  parameter PIN_OUT_N = 49
) (
  // Clock and reset
  input wire logic                 clk_i,
  input wire logic                 reset_i,
  // Test access pins
  input wire logic                 tck_i,
  input wire logic                 tms_i,
  input wire logic                 tdo_o,
  input wire logic                 tdo_oe_o,
  // Boundary and status
  input wire logic [PIN_IN_N-1:0]  pin_in_i,
  input wire logic [PIN_OUT_N-1:0] pin_out_o,
  input wire logic [PIN_OUT_N-1:0] core_out_i,
  input wire logic [PIN_IN_N-1:0]  core_in_o,
  input wire logic                 test_mode_o
);
  logic       tck_q;
  logic [2:0] hi_q;
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // Counts test-clock rises with mode-select high
  always_ff @(posedge clk_i)
  begin
    tck_q <= tck_i;
    if (reset_i || (tck_i && !tck_q && !tms_i))
      hi_q <= 3'h0;
    else if (tck_i && !tck_q && hi_q != 3'h7)
      hi_q <= hi_q + 3'h1;
  end
  a_reset_quiet: assert property (disable iff (1'b0)
    reset_i |=> !tdo_oe_o && !test_mode_o && pin_out_o == '0)
    else $error("outputs not quiet after reset");
  a_tdo_fall: assert property (
    $changed(tdo_o) |-> !tck_i && !$past(tck_i, 2))
    else $error("serial out moved off a falling edge");
  a_oe_fall: assert property (
    $changed(tdo_oe_o) |-> !tck_i && !$past(tck_i, 2))
    else $error("output enable moved off a falling edge");
  a_latch_fall: assert property (
    $changed(pin_out_o) && test_mode_o && $past(test_mode_o)
    |-> !$past(tck_i, 2)) else $error("pattern moved off a falling edge");
  a_normal_path: assert property (
    !test_mode_o && !$past(test_mode_o) && !$past(reset_i)
    |-> pin_out_o == $past(core_out_i)) else $error("core path broken");
  a_core_sync: assert property (
    $stable(pin_in_i) [*4] ##0 !test_mode_o |=> core_in_o == $past(pin_in_i))
    else $error("input path broken");
  a_mode_rise: assert property (
    $rose(test_mode_o) |-> !$past(tck_i, 2))
    else $error("test mode rose off a falling edge");
  a_tlr_entry: assert property (
    tck_i && !tck_q && tms_i && hi_q >= 3'h4 |->
    ##[1:6] (!test_mode_o && !tdo_oe_o)) else $error("no test reset");
  // Main scenarios
  c_tlr: cover property (tck_i && !tck_q && tms_i && hi_q == 3'h4);
  c_extest: cover property ($rose(test_mode_o));
  c_shift: cover property ($rose(tdo_oe_o));
endmodule // bst_tap_monitor
`default_nettype wire

/* verification/bst_host_model.sv */
// Behavioural external scan controller
`timescale 1ns/1ps
`default_nettype none
module bst_host_model (
  // Clock
  input  wire logic clk_i,
  // Test access pins
  output var  logic tck_o,
  output var  logic tms_o,
  output var  logic tdi_o,
  input  wire logic tdo_i,
  input  wire logic tdo_oe_i
);
  logic last_q;
  // Test clock stands low between bits
  initial
  begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
    last_q = 1'b0;
  end
  // One bit: 200 ns low, 200 ns high, mode and data held through the rise
  task automatic tick(input logic m, input logic d, output logic b);
  begin
    tms_o = m;
    tdi_o = d;
    repeat (4) @(negedge clk_i);
    b = tdo_oe_i ? tdo_i : ~last_q;
    last_q = b;
    tck_o = 1'b1;
    repeat (4) @(negedge clk_i);
    tck_o = 1'b0;
  end
  endtask
  // Moves the controller one step; data toggles as filler
  task automatic go(input logic m);
    logic b;
  begin
    tick(m, ~tdi_o, b);
  end
  endtask
  // Shifts n bits LSB first, leaves on the last, updates, idles
  task automatic shift(input int n, input logic [97:0] di,
                       output logic [97:0] dq);
    logic b;
  begin
    dq = '0;
    for (int i = 0; i < n; i++)
    begin
      tick(i == n - 1, di[i], b);
      dq[i] = b;
    end
    go(1'b1);
    go(1'b0);
  end
  endtask
  // Data scan from idle
  task automatic dr(input int n, input logic [97:0] di,
                    output logic [97:0] dq);
  begin
    go(1'b1);
    go(1'b0);
    go(1'b0);
    shift(n, di, dq);
  end
  endtask
  // Instruction scan from idle
  task automatic ir(input logic [2:0] c, output logic [97:0] dq);
  begin
    go(1'b1);
    go(1'b1);
    go(1'b0);
    go(1'b0);
    shift(3, {95'h0, c}, dq);
  end
  endtask
endmodule // bst_host_model
`default_nettype wire

/* verification/tb_top.sv */
// Testbench for the boundary scan test access port
`timescale 1ns/1ps
`default_nettype none
`include "bst_defines.vh"
module tb_top;
  logic        clk_i, reset_i, tck_i, tms_i, tdi_i;
  logic        tdo_o, tdo_oe_o, test_mode_o;
  logic [48:0] pin_in_i, pin_out_o, core_out_i, core_in_o;
  logic [97:0] so, pat;
  int          num_errors = 0;
  int          num_checks = 0;
  localparam logic [31:0] ID = {`BST_ID_REV_DEF, `BST_ID_PART_DEF,
                                `BST_ID_PROD_DEF, 1'b1};
  bst_tap i_bst_tap (.clk_i(clk_i), .reset_i(reset_i), .tck_i(tck_i),
    .tms_i(tms_i), .tdi_i(tdi_i), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o),
    .pin_in_i(pin_in_i), .pin_out_o(pin_out_o), .core_out_i(core_out_i),
    .core_in_o(core_in_o), .test_mode_o(test_mode_o));
  bst_host_model i_bst_host_model (.clk_i(clk_i), .tck_o(tck_i),
    .tms_o(tms_i), .tdi_o(tdi_i), .tdo_i(tdo_o), .tdo_oe_i(tdo_oe_o));
  // Compares and counts
  task automatic check(input string w, input logic [97:0] e,
                       input logic [97:0] g);
  begin
    num_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("mismatch %s exp %h got %h", w, e, g);
    end
  end
  endtask
  task automatic final_report();
  begin
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask
  // Loads an instruction and checks the captured pattern
  task automatic load(input logic [2:0] c);
  begin
    i_bst_host_model.ir(c, so);
    check("ir_capture", 98'h1, so & 98'h7);
  end
  endtask
  task automatic t_idcode();
  begin
    i_bst_host_model.dr(32, '0, so);
    check("idcode", ID, so & 98'hffffffff);
    $display("done idcode");
  end
  endtask
  task automatic t_bypass();
    logic [2:0] codes [5] = '{3'h7, 3'h1, 3'h2, 3'h3, 3'h5};
  begin
    pat = 98'h16d;
    foreach (codes[k])
    begin
      load(codes[k]);
      i_bst_host_model.dr(9, pat, so);
      check("bypass", (pat << 1) & 98'h1ff, so);
      check("bypass_mode", 98'h0, test_mode_o);
    end
    $display("done bypass");
  end
  endtask
  task automatic t_sample();
  begin
    load(3'h4);
    core_out_i = 49'h0_3c3c_f0f0_a5a5;
    repeat (2) @(negedge clk_i);
    check("sample_pins", core_out_i, pin_out_o);
    check("sample_core_in", pin_in_i, core_in_o);
    i_bst_host_model.dr(98, '0, so);
    check("sample_cap", {core_out_i, pin_in_i}, so);
    check("sample_hold", core_out_i, pin_out_o);
    $display("done sample");
  end
  endtask
  task automatic t_extest();
  begin
    load(3'h0);
    check("extest_mode", 98'h1, test_mode_o);
    check("preload", 98'h0, pin_out_o);
    pin_in_i = 49'h0_f00f_3c3c_1248;
    pat = {49'h0_aaaa_5555_1248, 49'h1_0000_ffff_0001};
    i_bst_host_model.dr(98, pat, so);
    check("extest_cap", pin_in_i, so & {49'h0, {49{1'b1}}});
    check("extest_drive", pat[97:49], pin_out_o);
    $display("done extest");
  end
  endtask
  task automatic t_reset();
  begin
    i_bst_host_model.go(1'b1);
    i_bst_host_model.go(1'b0);
    i_bst_host_model.go(1'b0);
    repeat (5) i_bst_host_model.go(1'b1);
    repeat (8) @(negedge clk_i);
    check("tlr_mode", 98'h0, test_mode_o);
    check("tlr_pins", core_out_i, pin_out_o);
    i_bst_host_model.go(1'b0);
    t_idcode();
    $display("done reset");
  end
  endtask
  // Reset pulse in mid-scan under extest
  task automatic t_midreset();
  begin
    load(3'h0);
    i_bst_host_model.go(1'b1);
    i_bst_host_model.go(1'b0);
    i_bst_host_model.go(1'b0);
    repeat (4) @(negedge clk_i);
    check("mid_oe", 98'h1, tdo_oe_o);
    check("mid_mode", 98'h1, test_mode_o);
    reset_i = 1'b1;
    repeat (4) @(negedge clk_i);
    check("rst_oe", 98'h0, tdo_oe_o);
    check("rst_mode", 98'h0, test_mode_o);
    check("rst_pins", 98'h0, pin_out_o);
    reset_i = 1'b0;
    repeat (4) @(negedge clk_i);
    check("rst_core", core_out_i, pin_out_o);
    i_bst_host_model.go(1'b0);
    t_idcode();
    $display("done midreset");
  end
  endtask
  // Clock
  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // Watchdog
  initial
  begin
    #500us;
    num_errors++;
    final_report();
  end
  // Main sequence
  initial
  begin
    reset_i = 1'b1;
    pin_in_i = 49'h0_5a5a_1234_8765;
    core_out_i = 49'h1_5555_aaaa_3c3c;
    repeat (16) @(negedge clk_i);
    reset_i = 1'b0;
    repeat (4) @(negedge clk_i);
    i_bst_host_model.go(1'b0);
    t_idcode();
    t_bypass();
    t_sample();
    t_extest();
    t_reset();
    t_midreset();
    final_report();
  end
endmodule // tb_top
bind bst_tap bst_tap_monitor #(.PIN_IN_N(PIN_IN_N), .PIN_OUT_N(PIN_OUT_N))
  i_bst_tap_monitor (.clk_i(clk_i), .reset_i(reset_i), .tck_i(tck_i),
  .tms_i(tms_i), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o), .pin_in_i(pin_in_i),
  .pin_out_o(pin_out_o), .core_out_i(core_out_i), .core_in_o(core_in_o),
  .test_mode_o(test_mode_o));
`default_nettype wire
